// file: hw/tce_pkg.sv
`default_nettype none
package tce_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TCE_OFS_UNIT   = 8'h00; // Unit clock enable
    localparam logic [7:0] TCE_OFS_MODE   = 8'h04; // Channel mode
    localparam logic [7:0] TCE_OFS_TRIG   = 8'h08; // Start and stop triggers
    localparam logic [7:0] TCE_OFS_STAT   = 8'h0c; // Enable status
    localparam logic [7:0] TCE_OFS_DATA   = 8'h10; // Reload value
    localparam logic [7:0] TCE_OFS_COUNT  = 8'h14; // Down counter
    localparam logic [7:0] TCE_OFS_OUTC   = 8'h18; // Output control
    localparam logic [7:0] TCE_OFS_PORT   = 8'h1c; // Port latch and port mode
    localparam logic [7:0] TCE_OFS_CSTAT  = 8'h20; // Channel status, unused

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TCE_B_UNIT_EN   = 0;  // UNIT: unit clock enable
    localparam int TCE_B_START_IRQ = 0;  // MODE: irq and toggle at start load
    localparam int TCE_B_EVT_MODE  = 1;  // MODE: 1 = event counter
    localparam int TCE_B_EDGE_LO   = 2;  // MODE: edge select, 2 bits
    localparam int TCE_B_PSC_LO    = 4;  // MODE: prescale shift, 4 bits
    localparam int TCE_B_START     = 0;  // TRIG: start trigger
    localparam int TCE_B_STOP      = 1;  // TRIG: stop trigger
    localparam int TCE_B_ENA       = 0;  // STAT: enable status
    localparam int TCE_B_OUT       = 0;  // OUTC: channel output bit
    localparam int TCE_B_OE        = 1;  // OUTC: output enable
    localparam int TCE_B_OMODE     = 2;  // OUTC: output mode bit
    localparam int TCE_B_OLEVEL    = 3;  // OUTC: output level bit
    localparam int TCE_B_LATCH     = 0;  // PORT: port latch
    localparam int TCE_B_PMODE     = 1;  // PORT: port mode, 0 = output

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          TCE_CW         = 16;     // Counter width
    localparam logic [7:0]  TCE_MODE_RST   = 8'h00;
    localparam logic [15:0] TCE_DATA_RST   = 16'h0000;
    localparam logic [3:0]  TCE_OUTC_RST   = 4'h0;
    localparam logic [1:0]  TCE_PORT_RST   = 2'h2;   // Port in input mode

    // Edge select codes
    localparam logic [1:0]  TCE_EDGE_RISE  = 2'h0;
    localparam logic [1:0]  TCE_EDGE_FALL  = 2'h1;

    // Channel sequencing states
    typedef enum logic [1:0] {
        TCE_IDLE  = 2'b00,   // Stopped, counter frozen
        TCE_ARMED = 2'b01,   // Started, waiting first count clock
        TCE_RUN   = 2'b10    // Counting
    } tce_state_t;
endpackage
`default_nettype wire

// file: hw/tce_count_clock.sv
`default_nettype none
// Count clock prescaler: one tick every 2**shiftSel cycles
module tce_count_clock
    import tce_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic [3:0] shiftSel,
    output logic            tick
);
    logic [15:0] cnt_q;    // Prescale counter
    logic [15:0] cnt_d;
    logic        tick_q;   // Registered tick
    logic        tick_d;
    logic [15:0] limit;    // Terminal value

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        limit  = 16'((17'h1 << shiftSel) - 17'h1);
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!run) begin
            // Held clear while the unit is off
            cnt_d = 16'h0000;
        end else if (cnt_q == limit) begin
            cnt_d  = 16'h0000;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule
`default_nettype wire

// file: hw/tce_edge_detect.sv
`default_nettype none
// Pin synchroniser and valid edge detector
module tce_edge_detect
    import tce_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       pinIn,
    input  wire logic [1:0] edgeSel,
    output logic            edgePulse
);
    logic sync1_q;   // First stage, read only by sync2_q
    logic sync2_q;   // Second stage
    logic prev_q;    // Previous synchronised level
    logic pulse_d;

    // ------------------------------------------------------------
    // Edge qualification
    // ------------------------------------------------------------
    always_comb begin
        unique case (edgeSel)
            TCE_EDGE_RISE: pulse_d = sync2_q & ~prev_q;
            TCE_EDGE_FALL: pulse_d = ~sync2_q & prev_q;
            default:       pulse_d = sync2_q ^ prev_q;   // Both edges
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign edgePulse = pulse_d;
endmodule
`default_nettype wire

// file: hw/tce_timer.sv
`default_nettype none
// Summary of operation
// - Start trigger always reads back zero
// - Start sets enable; next tick loads counter
// - Start load irq and toggle if mode set
// - Mode bit clear: no start irq, toggle
// - Decrement per tick; zero reloads, irq, toggles
// - Period is tick times reload plus one
// - Counter readable anytime; channel status register unused
// - Stop trigger self-clears, clears enable, halts
// - Stop freezes counter, output keeps level
// - Enabling output while stopped keeps level
// - Port output, latch zero: pin follows output
// - Output enable clear: software sets output
// - Unit disable resets channel, pin to port
// - Event irq after reload plus one edges
// - Event start loads counter from reload value
// - Event mode decrements per valid edge
// - Event zero reloads, raises irq, repeats
// - New reload value used at next reload
module tce_timer
    import tce_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer input pin, asynchronous
    input  wire logic        timerInputPin,
    // Output pin, drive and enable
    output logic             chanPinOut,
    output logic             chanPinOe,
    // Channel interrupt, one-cycle pulse
    output logic             chanInterrupt,
    // Channel enable status
    output logic             chanEnableStatus
);
    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    logic        pready_q;     // Access acknowledge
    logic        pready_d;
    logic        pslverr_q;    // Unmapped address answer
    logic        pslverr_d;
    logic [31:0] prdata_q;     // Read data
    logic [31:0] prdata_d;
    logic        wrEn;         // Write takes effect this edge
    logic        mapped;       // Address decodes

    // ------------------------------------------------------------
    // Register and channel state
    // ------------------------------------------------------------
    logic               unitEn_q;     // Unit clock enable
    logic               unitEn_d;
    logic [7:0]         chanMode_q;   // Channel mode register
    logic [7:0]         chanMode_d;
    logic [TCE_CW-1:0]  reloadVal_q;  // Reload value
    logic [TCE_CW-1:0]  reloadVal_d;
    logic [TCE_CW-1:0]  downCnt_q;    // Down counter
    logic [TCE_CW-1:0]  downCnt_d;
    logic [3:0]         outCtl_q;     // Output control bits
    logic [3:0]         outCtl_d;
    logic [1:0]         portCtl_q;    // Port latch and mode
    logic [1:0]         portCtl_d;
    logic               enaStat_q;    // Channel enable status
    logic               enaStat_d;
    logic               irq_q;        // Interrupt pulse
    logic               irq_d;
    tce_state_t         state_q;
    tce_state_t         state_d;
    logic               pinOut_q;     // Pin drive
    logic               pinOut_d;
    logic               pinOe_q;      // Pin enable
    logic               pinOe_d;

    // ------------------------------------------------------------
    // Decoded strobes
    // ------------------------------------------------------------
    logic startTrig;    // Start trigger write
    logic stopTrig;     // Stop trigger write
    logic countTick;    // Count clock tick
    logic validEdge;    // Qualified pin edge
    logic evtMode;      // Event counter mode
    logic step;         // One count event
    logic atZero;       // Terminal count

    // ------------------------------------------------------------
    // Count clock and pin edge sources
    // ------------------------------------------------------------
    tce_count_clock u_cclk (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .run      (unitEn_q),
        .shiftSel (chanMode_q[TCE_B_PSC_LO +: 4]),
        .tick     (countTick)
    );

    tce_edge_detect u_edge (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .pinIn     (timerInputPin),
        .edgeSel   (chanMode_q[TCE_B_EDGE_LO +: 2]),
        .edgePulse (validEdge)
    );

    // ------------------------------------------------------------
    // APB slave: one wait state, registered answer
    // ------------------------------------------------------------
    assign wrEn = psel & penable & pready_q & pwrite;

    always_comb begin
        mapped   = 1'b1;
        prdata_d = 32'h0000_0000;
        unique case (paddr)
            TCE_OFS_UNIT:  prdata_d[TCE_B_UNIT_EN] = unitEn_q;
            TCE_OFS_MODE:  prdata_d[7:0] = chanMode_q;
            TCE_OFS_TRIG:  prdata_d = 32'h0000_0000;
            TCE_OFS_STAT:  prdata_d[TCE_B_ENA] = enaStat_q;
            TCE_OFS_DATA:  prdata_d[TCE_CW-1:0] = reloadVal_q;
            TCE_OFS_COUNT: prdata_d[TCE_CW-1:0] = downCnt_q;
            TCE_OFS_OUTC:  prdata_d[3:0] = outCtl_q;
            TCE_OFS_PORT:  prdata_d[1:0] = portCtl_q;
            TCE_OFS_CSTAT: prdata_d = 32'h0000_0000;
            default:       mapped = 1'b0;
        endcase
        // Answer one cycle into the access phase
        pready_d  = psel & penable & ~pready_q;
        pslverr_d = psel & penable & ~pready_q & ~mapped;
        if (!(psel & penable & ~pready_q)) begin
            prdata_d = prdata_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // ------------------------------------------------------------
    // Trigger decode; triggers are never stored
    // ------------------------------------------------------------
    assign startTrig = wrEn & unitEn_q & (paddr == TCE_OFS_TRIG)
                     & pwdata[TCE_B_START];
    assign stopTrig  = wrEn & unitEn_q & (paddr == TCE_OFS_TRIG)
                     & pwdata[TCE_B_STOP];
    assign evtMode   = chanMode_q[TCE_B_EVT_MODE];
    assign step      = evtMode ? validEdge : countTick;
    assign atZero    = (downCnt_q == '0);

    // ------------------------------------------------------------
    // Channel next state
    // ------------------------------------------------------------
    always_comb begin
        unitEn_d    = unitEn_q;
        chanMode_d  = chanMode_q;
        reloadVal_d = reloadVal_q;
        downCnt_d   = downCnt_q;
        outCtl_d    = outCtl_q;
        portCtl_d   = portCtl_q;
        enaStat_d   = enaStat_q;
        state_d     = state_q;
        irq_d       = 1'b0;

        // Register writes; port register stays alive when unit is off
        if (wrEn && paddr == TCE_OFS_UNIT) begin
            unitEn_d = pwdata[TCE_B_UNIT_EN];
        end
        if (wrEn && paddr == TCE_OFS_PORT) begin
            portCtl_d = pwdata[1:0];
        end
        if (wrEn && unitEn_q) begin
            unique case (paddr)
                TCE_OFS_MODE: chanMode_d = pwdata[7:0];
                // Takes effect at the next reload only
                TCE_OFS_DATA: reloadVal_d = pwdata[TCE_CW-1:0];
                TCE_OFS_OUTC: begin
                    outCtl_d[3:1] = pwdata[3:1];
                    // Direct write only while output enable is clear
                    if (!outCtl_q[TCE_B_OE]) begin
                        outCtl_d[TCE_B_OUT] = pwdata[TCE_B_OUT];
                    end
                end
                default: ;
            endcase
        end

        // Sequencing
        if (stopTrig) begin
            // Counter and output hold their values
            enaStat_d = 1'b0;
            state_d   = TCE_IDLE;
        end else if (startTrig) begin
            enaStat_d = 1'b1;
            if (evtMode) begin
                downCnt_d = reloadVal_q;
                state_d   = TCE_RUN;
            end else begin
                state_d = TCE_ARMED;
            end
        end else begin
            unique case (state_q)
                TCE_IDLE: ;
                TCE_ARMED: begin
                    if (countTick) begin
                        downCnt_d = reloadVal_q;
                        state_d   = TCE_RUN;
                        // Start irq only in start-irq mode
                        if (chanMode_q[TCE_B_START_IRQ]) begin
                            irq_d = 1'b1;
                            if (outCtl_q[TCE_B_OE]) begin
                                outCtl_d[TCE_B_OUT] = ~outCtl_q[TCE_B_OUT];
                            end
                        end
                    end
                end
                TCE_RUN: begin
                    if (step) begin
                        if (atZero) begin
                            // Period = reload value plus one steps
                            downCnt_d = reloadVal_q;
                            irq_d     = 1'b1;
                            if (outCtl_q[TCE_B_OE]) begin
                                outCtl_d[TCE_B_OUT] = ~outCtl_q[TCE_B_OUT];
                            end
                        end else begin
                            downCnt_d = downCnt_q - 16'h0001;
                        end
                    end
                end
                default: state_d = TCE_IDLE;
            endcase
        end

        // Unit shutdown clears every channel register except the port register
        if (!unitEn_q) begin
            chanMode_d  = TCE_MODE_RST;
            reloadVal_d = TCE_DATA_RST;
            downCnt_d   = '0;
            outCtl_d    = TCE_OUTC_RST;
            enaStat_d   = 1'b0;
            state_d     = TCE_IDLE;
            irq_d       = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            unitEn_q    <= 1'b0;
            chanMode_q  <= TCE_MODE_RST;
            reloadVal_q <= TCE_DATA_RST;
            downCnt_q   <= '0;
            outCtl_q    <= TCE_OUTC_RST;
            portCtl_q   <= TCE_PORT_RST;
            enaStat_q   <= 1'b0;
            state_q     <= TCE_IDLE;
            irq_q       <= 1'b0;
        end else begin
            unitEn_q    <= unitEn_d;
            chanMode_q  <= chanMode_d;
            reloadVal_q <= reloadVal_d;
            downCnt_q   <= downCnt_d;
            outCtl_q    <= outCtl_d;
            portCtl_q   <= portCtl_d;
            enaStat_q   <= enaStat_d;
            state_q     <= state_d;
            irq_q       <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Pin multiplex: latch ORed with channel output
    // ------------------------------------------------------------
    // Latch zero lets the output through; with the unit off the
    // output bit is zero, so the latch alone drives the pin.
    always_comb begin
        pinOut_d = portCtl_q[TCE_B_LATCH]
                 | (unitEn_q & outCtl_q[TCE_B_OUT]);
        pinOe_d  = ~portCtl_q[TCE_B_PMODE];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinOut_q <= 1'b0;
            pinOe_q  <= 1'b0;
        end else begin
            pinOut_q <= pinOut_d;
            pinOe_q  <= pinOe_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign chanPinOut       = pinOut_q;
    assign chanPinOe        = pinOe_q;
    assign chanInterrupt    = irq_q;
    assign chanEnableStatus = enaStat_q;
endmodule
`default_nettype wire

// file: tb/tce_event_source.sv
`default_nettype none
// ----------------------------------------
// External event source on the input pin
// ----------------------------------------
module tce_event_source (
    input  wire logic clk,
    output logic      pinLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pin rests low between events
    initial pinLevel = 1'b0;
    // Wide pulses, so the sync delay never merges two edges
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            pinLevel <= 1'b1;
            repeat (4) @(posedge clk);
            pinLevel <= 1'b0;
        end
        // Let the last edge pass the synchroniser
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: tb/tce_timer_asserts.sv
`default_nettype none
// ----------------------------------------
// Port-level checker for the timer channel
// ----------------------------------------
module tce_timer_asserts
    import tce_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        timerInputPin,
    input  wire logic        chanPinOut,
    input  wire logic        chanPinOe,
    input  wire logic        chanInterrupt,
    input  wire logic        chanEnableStatus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic unitOn_q; // Unit enable as software last wrote it
    logic unitOn_d;
    logic wrAcc;    // Write completes this edge
    logic rdAcc;    // Read completes this edge
    assign wrAcc = psel && penable && pready && pwrite;
    assign rdAcc = psel && penable && pready && !pwrite;
    // Track the unit enable from bus writes
    always_comb begin
        unitOn_d = unitOn_q;
        if (wrAcc && paddr == TCE_OFS_UNIT)
            unitOn_d = pwdata[TCE_B_UNIT_EN];
    end
    always_ff @(posedge clk) begin
        if (sys_rst)
            unitOn_q <= 1'b0;
        else
            unitOn_q <= unitOn_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ready_timing_a: assert property ($rose(psel && penable) |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_error_a: assert property (psel && penable && pready && paddr > 8'h20 |-> pslverr)
        else $error("unmapped access not refused");
    trig_reads_zero_a: assert property (
        rdAcc && paddr == TCE_OFS_TRIG |-> prdata == 32'h0)
        else $error("trigger register not zero");
    cstat_unused_a: assert property (
        rdAcc && paddr == TCE_OFS_CSTAT |-> prdata == 32'h0)
        else $error("channel status not zero");
    start_enables_a: assert property (
        wrAcc && paddr == TCE_OFS_TRIG && pwdata[1:0] == 2'b01 && unitOn_q
        |=> chanEnableStatus)
        else $error("start did not set enable");
    stop_disables_a: assert property (
        wrAcc && paddr == TCE_OFS_TRIG && pwdata[TCE_B_STOP] |=> !chanEnableStatus)
        else $error("stop did not clear enable");
    unit_off_a: assert property (
        wrAcc && paddr == TCE_OFS_UNIT && !pwdata[TCE_B_UNIT_EN]
        |=> ##1 !chanEnableStatus && !chanInterrupt)
        else $error("unit off left channel active");
    idle_quiet_a: assert property ((!chanEnableStatus) [*3] |-> !chanInterrupt)
        else $error("interrupt while stopped");
    irq_seen_c: cover property (chanInterrupt);
    start_seen_c: cover property ($rose(chanEnableStatus));
    refuse_seen_c: cover property (pslverr);
endmodule
bind tce_timer tce_timer_asserts tce_timer_asserts_i (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerInputPin(timerInputPin), .chanPinOut(chanPinOut),
    .chanPinOe(chanPinOe), .chanInterrupt(chanInterrupt),
    .chanEnableStatus(chanEnableStatus));
`default_nettype wire

// file: tb/tce_timer_bench.sv
`default_nettype none
// ----------------------------------------
// Self-checking bench for the timer channel
// ----------------------------------------
module tce_timer_bench
    import tce_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        sysRst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;         // Event source level
    logic        pinOut;
    logic        pinOe;
    logic        irq;
    logic        ena;
    logic [31:0] rdv;         // Last read word
    logic        errv;        // Last error flag
    logic        lvl;         // Saved pin level
    int          nErrors = 0;
    int          nChecks = 0;
    int          cyc     = 0; // Free cycle count
    int          irqCnt  = 0;
    int          lastIrq = 0;
    int          prevIrq = 0;
    int          base;
    tce_timer tce_timer_i (
        .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timerInputPin(pin), .chanPinOut(pinOut),
        .chanPinOe(pinOe), .chanInterrupt(irq), .chanEnableStatus(ena));
    tce_event_source tce_event_source_i (.clk(clk), .pinLevel(pin));
    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Interrupt monitor: count and spacing of pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irqCnt  <= irqCnt + 1;
            prevIrq <= lastIrq;
            lastIrq <= cyc;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, with no timeout of its own
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No local timeout: pready ends this wait, or the hang guard if pready never comes
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv  = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    // Interrupts seen over the next n cycles
    task automatic win(input int n, input logic [31:0] e);
        base = irqCnt;
        repeat (n) @(posedge clk);
        chk(32'(irqCnt - base), e);
    endtask
    task automatic wrapUp();
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        repeat (6000) @(posedge clk);
        nErrors++;
        wrapUp();
    end
    // Main sequence
    initial begin
        sysRst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        apb(1'b1, TCE_OFS_TRIG, 32'h1);   // Start refused while unit is off
        rd(TCE_OFS_STAT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(errv), 32'h1);
        // Interval mode, tick every clock, period 3
        apb(1'b1, TCE_OFS_UNIT, 32'h1);
        apb(1'b1, TCE_OFS_PORT, 32'h0);
        apb(1'b1, TCE_OFS_DATA, 32'h2);
        apb(1'b1, TCE_OFS_MODE, 32'h1);
        apb(1'b1, TCE_OFS_OUTC, 32'h2);
        chk(32'(pinOe), 32'h1);
        apb(1'b1, TCE_OFS_TRIG, 32'h1);
        win(4, 32'h1);
        rd(TCE_OFS_TRIG, 32'h0);
        rd(TCE_OFS_STAT, 32'h1);
        repeat (12) @(posedge clk);
        chk(32'(lastIrq - prevIrq), 32'h3);
        lvl = pinOut;
        repeat (3) @(posedge clk);
        chk(32'(pinOut), 32'(!lvl));
        // Stop freezes count and output
        apb(1'b1, TCE_OFS_TRIG, 32'h2);
        rd(TCE_OFS_STAT, 32'h0);
        apb(1'b0, TCE_OFS_COUNT, 32'h0);
        base = int'(rdv);
        lvl = pinOut;
        repeat (10) @(posedge clk);
        chk(32'(pinOut), 32'(lvl));
        rd(TCE_OFS_COUNT, 32'(base));
        rd(TCE_OFS_CSTAT, 32'h0);
        // Prescaled tick: 4 clocks a tick, 12 clocks a period
        apb(1'b1, TCE_OFS_MODE, 32'h21);
        apb(1'b1, TCE_OFS_TRIG, 32'h1);
        repeat (60) @(posedge clk);
        chk(32'(lastIrq - prevIrq), 32'hc);
        apb(1'b1, TCE_OFS_TRIG, 32'h2);
        // No interrupt at the first load
        apb(1'b1, TCE_OFS_MODE, 32'h0);
        apb(1'b1, TCE_OFS_TRIG, 32'h1);
        win(4, 32'h0);
        apb(1'b1, TCE_OFS_TRIG, 32'h2);
        // Software owns the output while enable is clear
        apb(1'b1, TCE_OFS_OUTC, 32'h0);
        apb(1'b1, TCE_OFS_OUTC, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(pinOut), 32'h1);
        apb(1'b1, TCE_OFS_OUTC, 32'h3);
        repeat (2) @(posedge clk);
        chk(32'(pinOut), 32'h1);
        // Event counter, reload changed mid-count
        apb(1'b1, TCE_OFS_OUTC, 32'h0);
        apb(1'b1, TCE_OFS_MODE, 32'h2);
        apb(1'b1, TCE_OFS_DATA, 32'h3);
        apb(1'b1, TCE_OFS_TRIG, 32'h1);
        rd(TCE_OFS_COUNT, 32'h3);
        tce_event_source_i.pulses(2);
        rd(TCE_OFS_COUNT, 32'h1);
        base = irqCnt;
        tce_event_source_i.pulses(1);
        chk(32'(irqCnt - base), 32'h0);
        apb(1'b1, TCE_OFS_DATA, 32'h1);
        tce_event_source_i.pulses(1);
        chk(32'(irqCnt - base), 32'h1);
        tce_event_source_i.pulses(2);
        chk(32'(irqCnt - base), 32'h2);
        // Hand pin to the port latch, then shut the unit down
        apb(1'b1, TCE_OFS_PORT, 32'h1);
        apb(1'b1, TCE_OFS_OUTC, 32'h0);
        apb(1'b1, TCE_OFS_UNIT, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(pinOut), 32'h1);
        rd(TCE_OFS_OUTC, 32'h0);
        rd(TCE_OFS_DATA, 32'h0);
        rd(TCE_OFS_COUNT, 32'h0);
        wrapUp();
    end
endmodule
`default_nettype wire
